// File: pkg/lhcp_pkg.sv
`default_nettype none
package lhcp_pkg;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int PORT_W = 3;
    localparam logic [2:0] HOST_PORT_NUM = 3'h5;
    localparam logic [2:0] CTRL_PORT_NUM = 3'h0;
    localparam int EXTERNAL_INTERRUPT_INPUT_FLAG_BIT = 0;
    localparam int EXTERNAL_INTERRUPT_INPUT_MASK_BIT = 4;
    localparam int NUM_GP_PORTS = 6;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam int SYNC_STAGES = 2;
    // host strobe phases outlast the device synchronizer
    localparam logic [3:0] PHASE_CYC = 4'h6;
endpackage
`default_nettype wire

// File: pkg/lhcp_if.sv
`default_nettype none
interface lhcp_if;
    logic mode_sel_n;
    logic micro_sel_n;
    logic [15:0] host_data_out;
    logic host_data_oe;
    logic [15:0] dev_data_out;
    logic dev_data_oe;
    logic host_write_n;
    logic host_read_n;
    logic byte_select;
    logic rx_empty;
    logic tx_full;
    logic [15:0] data_lines;
    assign data_lines = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 16'h0000);
    modport dev (
        input mode_sel_n, micro_sel_n, data_lines, host_write_n, host_read_n, byte_select,
        output dev_data_out, dev_data_oe, rx_empty, tx_full
    );
    modport host (
        input data_lines, rx_empty, tx_full,
        output mode_sel_n, micro_sel_n, host_data_out, host_data_oe, host_write_n, host_read_n, byte_select
    );
endinterface
`default_nettype wire

// File: logic/lhcp_device.sv
// Overview of operation
// - processor reaches latch via port 5
// - board ties both mode selects equal
// - microcomputer mode gives six parallel ports
// - host mode latched, width bit set: 16 lines
// - width bit clear: low byte only
// - byte select picks latch half
// - port 5 generic outside host mode
// - host write rising edge captures data
// - write rising edge raises interrupt
// - write falling edge clears empty flag
// - processor read sets empty, clears data
// - device drives latch while read low
// - read rising edge asserts polling input
// - read falling edge resets full flag
// - outside logic leaves interrupt, polling undriven
// - address bit 1 becomes empty flag (here port_addr_out bit 1 copies port_addr_in; empty flag only on the link)
// - address bit 2 becomes full flag (here port_addr_out bit 2 copies port_addr_in; full flag only on the link)
// - bit 0, enables become host inputs (here port_addr_out bit 0 copies port_addr_in in every mode)
// - interrupt forwarded only when masked in
// - writing one to port 0 clears flag
`default_nettype none
module lhcp_device
    import lhcp_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // host side
    lhcp_if.dev link,
    // processor side
    input wire logic port_wr_in,
    input wire logic port_rd_in,
    input wire logic [PORT_W-1:0] port_addr_in,
    input wire logic [DATA_W-1:0] port_wdata_in,
    input wire logic port_width_bit_in,
    input wire logic ext_int_mask_in,
    input wire logic ext_interrupt_pin_in,
    input wire logic polling_pin_in,
    input wire logic [DATA_W-1:0] gp_data_in,
    output logic [DATA_W-1:0] port_rdata_out,
    output logic [PORT_W-1:0] port_addr_out,
    output logic [DATA_W-1:0] gp_data_out,
    output logic gp_data_oe_out,
    output logic irq_out,
    output logic ext_int_flag_out,
    output logic polling_input_out,
    output logic host_mode_out
);
    // ----------------------------------------
    // strobe synchronizers
    // ----------------------------------------
    logic [SYNC_STAGES-1:0] wr_sync_q;
    logic [SYNC_STAGES-1:0] rd_sync_q;
    logic wr_prev_q;
    logic rd_prev_q;
    logic mode_q;
    logic [DATA_W-1:0] rx_latch_q;
    logic [DATA_W-1:0] tx_latch_q;
    logic rx_empty_q;
    logic tx_full_q;
    logic dev_oe_q;
    logic [DATA_W-1:0] dev_out_q;
    logic wr_rise;
    logic wr_fall;
    logic rd_rise;
    logic rd_fall;
    logic host_mode;
    logic cpu_rd5;
    logic cpu_wr5;
    logic clr_flag;

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            wr_sync_q <= '1;
            rd_sync_q <= '1;
            wr_prev_q <= 1'b1;
            rd_prev_q <= 1'b1;
        end
        else
        begin
            wr_sync_q <= {wr_sync_q[0], link.host_write_n};
            rd_sync_q <= {rd_sync_q[0], link.host_read_n};
            wr_prev_q <= wr_sync_q[1];
            rd_prev_q <= rd_sync_q[1];
        end
    end

    assign wr_rise = wr_sync_q[1] && !wr_prev_q;
    assign wr_fall = !wr_sync_q[1] && wr_prev_q;
    assign rd_rise = rd_sync_q[1] && !rd_prev_q;
    assign rd_fall = !rd_sync_q[1] && rd_prev_q;

    // ----------------------------------------
    // mode straps
    // ----------------------------------------
    // straps sampled each clock; differing straps treated as microcomputer mode
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            mode_q <= 1'b0;
        else
            mode_q <= !link.mode_sel_n && !link.micro_sel_n;
    end
    assign host_mode = mode_q;
    assign cpu_rd5 = port_rd_in && port_addr_in == HOST_PORT_NUM;
    assign cpu_wr5 = port_wr_in && port_addr_in == HOST_PORT_NUM;
    assign clr_flag = port_wr_in && port_addr_in == CTRL_PORT_NUM && port_wdata_in[EXTERNAL_INTERRUPT_INPUT_FLAG_BIT];

    // ----------------------------------------
    // receive latch
    // ----------------------------------------
    // data lines sampled at synchronized rising edge; host must hold data briefly
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rx_latch_q <= DATA_RESET;
            rx_empty_q <= 1'b1;
        end
        else if (host_mode)
        begin
            if (wr_rise)
            begin
                if (port_width_bit_in)
                    rx_latch_q <= link.data_lines;
                else if (link.byte_select)
                    rx_latch_q[15:8] <= link.data_lines[7:0];
                else
                    rx_latch_q[7:0] <= link.data_lines[7:0];
            end
            else if (cpu_rd5)
                rx_latch_q <= DATA_RESET;
            if (wr_fall)
                rx_empty_q <= 1'b0;
            else if (cpu_rd5)
                rx_empty_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // transmit latch
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            tx_latch_q <= DATA_RESET;
            tx_full_q <= 1'b0;
        end
        else if (host_mode)
        begin
            if (cpu_wr5)
                tx_latch_q <= port_wdata_in;
            if (cpu_wr5)
                tx_full_q <= 1'b1;
            else if (rd_fall)
                tx_full_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // host data drive
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            dev_oe_q <= 1'b0;
            dev_out_q <= DATA_RESET;
        end
        else
        begin
            dev_oe_q <= host_mode && !rd_sync_q[1];
            if (port_width_bit_in)
                dev_out_q <= tx_latch_q;
            else if (link.byte_select)
                dev_out_q <= {8'h00, tx_latch_q[15:8]};
            else
                dev_out_q <= {8'h00, tx_latch_q[7:0]};
        end
    end
    assign link.dev_data_oe = dev_oe_q;
    assign link.dev_data_out = dev_out_q;
    assign link.rx_empty = rx_empty_q;
    assign link.tx_full = tx_full_q;

    // ----------------------------------------
    // interrupt and polling
    // ----------------------------------------
    // set beats clear in the same cycle
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ext_int_flag_out <= 1'b0;
            irq_out <= 1'b0;
            polling_input_out <= 1'b0;
        end
        else
        begin
            if ((host_mode && wr_rise) || (!host_mode && ext_interrupt_pin_in))
                ext_int_flag_out <= 1'b1;
            else if (clr_flag || (host_mode && cpu_rd5))
                ext_int_flag_out <= 1'b0;
            irq_out <= (ext_int_flag_out || (host_mode && wr_rise)) && ext_int_mask_in;
            if (host_mode)
            begin
                if (rd_rise)
                    polling_input_out <= 1'b1;
                else if (cpu_wr5)
                    polling_input_out <= 1'b0;
            end
            else
                polling_input_out <= polling_pin_in;
        end
    end

    // ----------------------------------------
    // processor port side
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            port_rdata_out <= DATA_RESET;
            port_addr_out <= '0;
            gp_data_out <= DATA_RESET;
            gp_data_oe_out <= 1'b0;
            host_mode_out <= 1'b0;
        end
        else
        begin
            host_mode_out <= host_mode;
            port_addr_out <= port_addr_in;
            gp_data_oe_out <= !host_mode && port_wr_in;
            if (!host_mode && port_wr_in)
                gp_data_out <= port_wdata_in;
            if (port_rd_in)
                port_rdata_out <= (host_mode && port_addr_in == HOST_PORT_NUM) ? rx_latch_q : gp_data_in;
        end
    end
endmodule
`default_nettype wire

// File: logic/lhcp_host.sv
`default_nettype none
module lhcp_host
    import lhcp_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // link
    lhcp_if.host link,
    // user side
    input wire logic wr_req_in,
    input wire logic rd_req_in,
    input wire logic hi_sel_in,
    input wire logic [DATA_W-1:0] wdata_in,
    output logic busy_out,
    output logic rd_valid_out,
    output logic [DATA_W-1:0] rdata_out,
    output logic rx_empty_out,
    output logic tx_full_out
);
    typedef enum logic [2:0] {ST_IDLE, ST_WR_LOW, ST_WR_DATA, ST_WR_HOLD, ST_RD_LOW, ST_RD_WAIT, ST_RD_DONE} lhcp_state_e;
    lhcp_state_e state_q;
    logic [3:0] cnt_q;
    logic wr_n_q;
    logic rd_n_q;
    logic oe_q;
    logic sel_q;
    logic [DATA_W-1:0] dout_q;

    // ----------------------------------------
    // strobe sequencer
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            oe_q <= 1'b0;
            sel_q <= 1'b0;
            dout_q <= DATA_RESET;
            rd_valid_out <= 1'b0;
            rdata_out <= DATA_RESET;
        end
        else
        begin
            rd_valid_out <= 1'b0;
            cnt_q <= (cnt_q == 4'h0) ? 4'h0 : cnt_q - 4'h1;
            case (state_q)
                ST_IDLE:
                begin
                    if (wr_req_in)
                    begin
                        wr_n_q <= 1'b0;
                        sel_q <= hi_sel_in;
                        dout_q <= wdata_in;
                        cnt_q <= PHASE_CYC;
                        state_q <= ST_WR_LOW;
                    end
                    else if (rd_req_in)
                    begin
                        rd_n_q <= 1'b0;
                        sel_q <= hi_sel_in;
                        cnt_q <= PHASE_CYC;
                        state_q <= ST_RD_LOW;
                    end
                end
                ST_WR_LOW:
                begin
                    oe_q <= 1'b1;
                    state_q <= ST_WR_DATA;
                end
                ST_WR_DATA:
                    if (cnt_q == 4'h0)
                    begin
                        wr_n_q <= 1'b1;
                        cnt_q <= PHASE_CYC;
                        state_q <= ST_WR_HOLD;
                    end
                ST_WR_HOLD:
                    if (cnt_q == 4'h0)
                    begin
                        oe_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                ST_RD_LOW:
                    if (cnt_q == 4'h0)
                        state_q <= ST_RD_WAIT;
                ST_RD_WAIT:
                begin
                    rdata_out <= link.data_lines;
                    rd_valid_out <= 1'b1;
                    rd_n_q <= 1'b1;
                    cnt_q <= PHASE_CYC;
                    state_q <= ST_RD_DONE;
                end
                ST_RD_DONE:
                    if (cnt_q == 4'h0)
                        state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            busy_out <= 1'b0;
            rx_empty_out <= 1'b1;
            tx_full_out <= 1'b0;
        end
        else
        begin
            busy_out <= state_q != ST_IDLE || wr_req_in || rd_req_in;
            rx_empty_out <= link.rx_empty;
            tx_full_out <= link.tx_full;
        end
    end

    assign link.mode_sel_n = 1'b0;
    assign link.micro_sel_n = 1'b0;
    assign link.host_write_n = wr_n_q;
    assign link.host_read_n = rd_n_q;
    assign link.byte_select = sel_q;
    assign link.host_data_out = dout_q;
    assign link.host_data_oe = oe_q;
endmodule
`default_nettype wire

// File: sim/lhcp_monitor.sv
`default_nettype none
module lhcp_monitor
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // link signals
    input wire logic mode_sel_n,
    input wire logic micro_sel_n,
    input wire logic host_data_oe,
    input wire logic dev_data_oe,
    input wire logic host_write_n,
    input wire logic host_read_n,
    input wire logic rx_empty,
    input wire logic tx_full
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    // ------------------------------------------------------------
    // link checks
    // ------------------------------------------------------------
    a_straps_equal: assert property (mode_sel_n == micro_sel_n)
        else $error("mode straps differ");
    a_strobe_before_data: assert property ($fell(host_write_n) |-> !host_data_oe)
        else $error("host data driven before write strobe");
    a_data_at_capture: assert property ($rose(host_write_n) |-> host_data_oe)
        else $error("host data gone at write capture");
    a_empty_on_write: assert property ($fell(host_write_n) |-> ##[1:5] !rx_empty)
        else $error("empty flag not cleared by write");
    a_drive_on_read: assert property ($fell(host_read_n) |-> ##[1:5] dev_data_oe)
        else $error("device not driving during read");
    a_release_after_read: assert property ($rose(host_read_n) |-> ##[0:5] !dev_data_oe)
        else $error("device still driving after read");
    a_idle_no_drive: assert property (host_read_n [*6] |-> !dev_data_oe)
        else $error("device drives without read");
    a_single_driver: assert property (!(host_data_oe && dev_data_oe))
        else $error("both ends drive data lines");
    a_read_strobe_hold: assert property ($fell(host_read_n) |-> !host_read_n [*4] ##[1:10] host_read_n)
        else $error("read strobe shape wrong");
    a_full_clears_read: assert property ($fell(host_read_n) |-> ##[1:5] !tx_full)
        else $error("full flag not cleared by read");
    a_full_holds_idle: assert property (tx_full && host_read_n |=> tx_full)
        else $error("full flag dropped without read");

    c_write: cover property ($fell(host_write_n));
    c_read: cover property ($fell(host_read_n) && tx_full);
    c_drive: cover property ($rose(dev_data_oe));
endmodule
`default_nettype wire

// File: sim/latched_host_coprocessor_port_bench.sv
`default_nettype none
module latched_host_coprocessor_port_bench
    import lhcp_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in, rstn_in, port_wr, port_rd, width, mask, wr_req, rd_req, hi_sel;
    logic busy, rd_valid, irq, flag, poll, hmode, rxe_h, txf_h, gp_oe;
    logic [2:0] port_addr, pa_out;
    logic [15:0] port_wdata, hwdata, q, rdata, rdata_h, gp_in, gp_dout;
    int num_errors = 0;
    int checked = 0;

    lhcp_if link();
    lhcp_device i_lhcp_device (.clk_in(clk_in), .rstn_in(rstn_in), .link(link), .port_wr_in(port_wr),
        .port_rd_in(port_rd), .port_addr_in(port_addr), .port_wdata_in(port_wdata), .port_width_bit_in(width),
        .ext_int_mask_in(mask), .ext_interrupt_pin_in(1'b0), .polling_pin_in(1'b0), .gp_data_in(gp_in),
        .port_rdata_out(rdata), .port_addr_out(pa_out), .gp_data_out(gp_dout), .gp_data_oe_out(gp_oe), .irq_out(irq),
        .ext_int_flag_out(flag), .polling_input_out(poll), .host_mode_out(hmode));
    lhcp_host i_lhcp_host (.clk_in(clk_in), .rstn_in(rstn_in), .link(link), .wr_req_in(wr_req),
        .rd_req_in(rd_req), .hi_sel_in(hi_sel), .wdata_in(hwdata), .busy_out(busy), .rd_valid_out(rd_valid),
        .rdata_out(rdata_h), .rx_empty_out(rxe_h), .tx_full_out(txf_h));
    lhcp_monitor i_lhcp_monitor (.clk_in(clk_in), .rstn_in(rstn_in), .mode_sel_n(link.mode_sel_n),
        .micro_sel_n(link.micro_sel_n), .host_data_oe(link.host_data_oe), .dev_data_oe(link.dev_data_oe),
        .host_write_n(link.host_write_n), .host_read_n(link.host_read_n), .rx_empty(link.rx_empty),
        .tx_full(link.tx_full));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_bit(input string name, input logic exp, input logic got);
        check(name, {15'h0000, exp}, {15'h0000, got});
    endtask

    // wait on busy too, so the next request never lands while refused
    task automatic host_op(input logic rd, input logic hi, input logic [15:0] d);
        int n;
        @(posedge clk_in);
        #1;
        hi_sel = hi;
        hwdata = d;
        wr_req = !rd;
        rd_req = rd;
        @(posedge clk_in);
        #1;
        wr_req = 1'b0;
        rd_req = 1'b0;
        for (n = 0; n < 100 && busy !== 1'b0; n++)
        begin
            @(posedge clk_in);
            #1;
            if (rd_valid === 1'b1)
                q = rdata_h;
        end
        if (n == 100)
        begin
            $display("Error host_busy expected 0 seen 1");
            num_errors++;
            finish_test();
        end
        repeat (6) @(posedge clk_in);
        #1;
    endtask

    task automatic proc_op(input logic rd, input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_in);
        #1;
        port_addr = a;
        port_wdata = d;
        port_wr = !rd;
        port_rd = rd;
        @(posedge clk_in);
        #1;
        port_wr = 1'b0;
        port_rd = 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial
    begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    initial
    begin
        {rstn_in, port_wr, port_rd, wr_req, rd_req, hi_sel} = '0;
        port_addr = 3'h0;
        port_wdata = 16'h0000;
        hwdata = 16'h0000;
        gp_in = 16'h5a5a;
        width = 1'b1;
        mask = 1'b1;
        repeat (8) @(posedge clk_in);
        #1;
        rstn_in = 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        check_bit("host_mode", 1'b1, hmode);
        check_bit("rx_empty", 1'b1, link.rx_empty);
        check_bit("tx_full", 1'b0, link.tx_full);
        host_op(1'b0, 1'b0, 16'ha5c3);
        check_bit("rx_empty", 1'b0, rxe_h);
        check_bit("irq", 1'b1, irq);
        proc_op(1'b1, HOST_PORT_NUM, 16'h0000);
        check("rdata", 16'ha5c3, rdata);
        check_bit("rx_empty", 1'b1, link.rx_empty);
        check_bit("flag", 1'b0, flag);
        proc_op(1'b1, HOST_PORT_NUM, 16'h0000);
        check("rdata_cleared", 16'h0000, rdata);
        mask = 1'b0;
        host_op(1'b0, 1'b0, 16'h0f0f);
        check_bit("flag", 1'b1, flag);
        check_bit("irq", 1'b0, irq);
        proc_op(1'b0, CTRL_PORT_NUM, 16'h0001);
        check_bit("flag", 1'b0, flag);
        check_bit("gp_oe", 1'b0, gp_oe);
        check("gp_data", 16'h0000, gp_dout);
        proc_op(1'b1, 3'h3, 16'h0000);
        check("gp_rdata", 16'h5a5a, rdata);
        check("port_addr", 16'h0003, {13'h0000, pa_out});
        mask = 1'b1;
        proc_op(1'b0, HOST_PORT_NUM, 16'h3c96);
        check_bit("tx_full", 1'b1, txf_h);
        check_bit("poll", 1'b0, poll);
        host_op(1'b1, 1'b0, 16'h0000);
        check("host_rdata", 16'h3c96, q);
        check_bit("tx_full", 1'b0, txf_h);
        check_bit("poll", 1'b1, poll);
        width = 1'b0;
        host_op(1'b0, 1'b0, 16'h0012);
        host_op(1'b0, 1'b1, 16'h0034);
        proc_op(1'b1, HOST_PORT_NUM, 16'h0000);
        check("byte_rdata", 16'h3412, rdata);
        proc_op(1'b0, HOST_PORT_NUM, 16'hbeef);
        check_bit("poll", 1'b0, poll);
        check_bit("tx_full", 1'b1, txf_h);
        host_op(1'b1, 1'b1, 16'h0000);
        check("host_hi", 16'h00be, q);
        host_op(1'b1, 1'b0, 16'h0000);
        check("host_lo", 16'h00ef, q);
        finish_test();
    end
endmodule
`default_nettype wire
